// >>> src/cem_defs.svh
`ifndef CEM_DEFS_SVH
`define CEM_DEFS_SVH

`define CEM_REG_W 8
`define CEM_ADDR_W 8

// Register offsets on the serial register port
`define CEM_OFS_MASK_C 8'h2A
`define CEM_OFS_MASK_D 8'h2B
`define CEM_OFS_MASK_F 8'h2C

// Reset values
`define CEM_RST_MASK_C 8'h00
`define CEM_RST_MASK_D 8'h00
`define CEM_RST_MASK_F 8'h00

// Writable bits; all others are reserved and read as zero
`define CEM_WR_MASK_C 8'h7F
`define CEM_WR_MASK_D 8'h1F
`define CEM_WR_MASK_F 8'hFF

// Field positions, charger_event_mask_c
`define CEM_C_DATALINE_DONE 6
`define CEM_C_CONV_DONE 5
`define CEM_C_SYS_MIN_REG 4
`define CEM_C_FAST_TMR 3
`define CEM_C_TRICKLE_TMR 2
`define CEM_C_PRECHG_TMR 1
`define CEM_C_TOPOFF_TMR 0

// Field positions, charger_event_mask_d
`define CEM_D_BATT_LOW_REV 4
`define CEM_D_THERM_COLD 3
`define CEM_D_THERM_COOL 2
`define CEM_D_THERM_WARM 1
`define CEM_D_THERM_HOT 0

// Field positions, fault_event_mask_a
`define CEM_F_BATT_CUR_REG 7
`define CEM_F_BUS_OVP 6
`define CEM_F_BATT_OVP 5
`define CEM_F_IN_OCP 4
`define CEM_F_BATT_OCP 3
`define CEM_F_CONV_OCP 2
`define CEM_F_IN2_OVP 1
`define CEM_F_IN1_OVP 0

`endif

// >>> src/cem_event_masks.sv
`timescale 1ns/10ps
`include "cem_defs.svh"

// Functional notes
// - Mask c bit6 gates dataline detect done
// - Mask c bit5 gates one-shot conversion done
// - Mask c bit4 gates min-system enter/exit
// - Mask c bits3-0 gate four charge timers
// - Mask d bit4 gates battery-low reverse event
// - Mask d bits3-0 gate thermistor zone crossings
// - Mask d clears on register reset, watchdog
// - Fault mask bit7 gates battery current regulation
// - Fault bits 6,5,1,0 gate over-voltage entries
// - Fault bits 4,3,2 gate over-current faults
// - Mask c, fault clear on reset only
// - Reserved mask bits read as zero
module cem_event_masks
    import cem_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic reg_rst_i,
    input wire logic wdog_expire_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    output logic reg_hit_o,
    input wire logic conv_oneshot_i,
    input wire logic ev_dataline_detect_done_i,
    input wire logic ev_conv_done_i,
    input wire logic ev_sys_min_reg_i,
    input wire logic ev_fast_charge_timer_i,
    input wire logic ev_trickle_timer_i,
    input wire logic ev_precharge_timer_i,
    input wire logic ev_topoff_timer_i,
    input wire logic ev_batt_low_reverse_i,
    input wire logic ev_therm_cold_i,
    input wire logic ev_therm_cool_i,
    input wire logic ev_therm_warm_i,
    input wire logic ev_therm_hot_i,
    input wire logic ev_batt_current_reg_i,
    input wire logic ev_bus_overvolt_i,
    input wire logic ev_batt_overvolt_i,
    input wire logic ev_input_overcurrent_i,
    input wire logic ev_batt_overcurrent_i,
    input wire logic ev_converter_overcurrent_i,
    input wire logic ev_input2_overvolt_i,
    input wire logic ev_input1_overvolt_i,
    output logic [7:0] flag_set_c_o,
    output logic [7:0] flag_set_d_o,
    output logic [7:0] flag_set_f_o,
    output logic int_pulse_o
);

    cem_state_s state_q;
    cem_state_s state_d;
    cem_byte_t mask_c;
    cem_byte_t mask_d;
    cem_byte_t mask_f;
    cem_byte_t ev_c;
    cem_byte_t ev_d;
    cem_byte_t ev_f;
    logic wr_c;
    logic wr_d;
    logic wr_f;
    logic clr_d;
    logic any_unmasked;

    assign wr_c = reg_wr_i && (reg_addr_i == `CEM_OFS_MASK_C);
    assign wr_d = reg_wr_i && (reg_addr_i == `CEM_OFS_MASK_D);
    assign wr_f = reg_wr_i && (reg_addr_i == `CEM_OFS_MASK_F);
    assign clr_d = reg_rst_i || wdog_expire_i;

    // Watchdog deliberately left off the c and fault masks
    cem_mask_reg #(
        .REG_W(`CEM_REG_W),
        .WR_MASK(`CEM_WR_MASK_C),
        .RST_VAL(`CEM_RST_MASK_C)
    ) u_mask_c (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .soft_clr_i(reg_rst_i),
        .wr_i(wr_c),
        .wdata_i(reg_wdata_i),
        .value_o(mask_c)
    );

    cem_mask_reg #(
        .REG_W(`CEM_REG_W),
        .WR_MASK(`CEM_WR_MASK_D),
        .RST_VAL(`CEM_RST_MASK_D)
    ) u_mask_d (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .soft_clr_i(clr_d),
        .wr_i(wr_d),
        .wdata_i(reg_wdata_i),
        .value_o(mask_d)
    );

    cem_mask_reg #(
        .REG_W(`CEM_REG_W),
        .WR_MASK(`CEM_WR_MASK_F),
        .RST_VAL(`CEM_RST_MASK_F)
    ) u_mask_f (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .soft_clr_i(reg_rst_i),
        .wr_i(wr_f),
        .wdata_i(reg_wdata_i),
        .value_o(mask_f)
    );

    always_comb
    begin
        ev_c = 8'h00;
        ev_c[`CEM_C_DATALINE_DONE] = ev_dataline_detect_done_i;
        // Conversion done only counts in one-shot mode
        ev_c[`CEM_C_CONV_DONE] = ev_conv_done_i && conv_oneshot_i;
        ev_c[`CEM_C_SYS_MIN_REG] = ev_sys_min_reg_i;
        ev_c[`CEM_C_FAST_TMR] = ev_fast_charge_timer_i;
        ev_c[`CEM_C_TRICKLE_TMR] = ev_trickle_timer_i;
        ev_c[`CEM_C_PRECHG_TMR] = ev_precharge_timer_i;
        ev_c[`CEM_C_TOPOFF_TMR] = ev_topoff_timer_i;
        ev_d = 8'h00;
        ev_d[`CEM_D_BATT_LOW_REV] = ev_batt_low_reverse_i;
        ev_d[`CEM_D_THERM_COLD] = ev_therm_cold_i;
        ev_d[`CEM_D_THERM_COOL] = ev_therm_cool_i;
        ev_d[`CEM_D_THERM_WARM] = ev_therm_warm_i;
        ev_d[`CEM_D_THERM_HOT] = ev_therm_hot_i;
        ev_f = 8'h00;
        ev_f[`CEM_F_BATT_CUR_REG] = ev_batt_current_reg_i;
        ev_f[`CEM_F_BUS_OVP] = ev_bus_overvolt_i;
        ev_f[`CEM_F_BATT_OVP] = ev_batt_overvolt_i;
        ev_f[`CEM_F_IN_OCP] = ev_input_overcurrent_i;
        ev_f[`CEM_F_BATT_OCP] = ev_batt_overcurrent_i;
        ev_f[`CEM_F_CONV_OCP] = ev_converter_overcurrent_i;
        ev_f[`CEM_F_IN2_OVP] = ev_input2_overvolt_i;
        ev_f[`CEM_F_IN1_OVP] = ev_input1_overvolt_i;
    end

    // Mask in force is the one registered before this cycle's write
    assign any_unmasked = |cem_unmasked(ev_c, mask_c)
        || |cem_unmasked(ev_d, mask_d)
        || |cem_unmasked(ev_f, mask_f);

    always_comb
    begin
        state_d = state_q;
        state_d.int_pulse = any_unmasked;
        // Flag sources see every event regardless of its mask
        state_d.flag_c = ev_c;
        state_d.flag_d = ev_d;
        state_d.flag_f = ev_f;
        state_d.rvalid = reg_rd_i;
        state_d.rhit = 1'b0;
        state_d.rdata = 8'h00;
        if (reg_rd_i)
        begin
            unique case (reg_addr_i)
                `CEM_OFS_MASK_C:
                begin
                    state_d.rdata = mask_c & `CEM_WR_MASK_C;
                    state_d.rhit = 1'b1;
                end
                `CEM_OFS_MASK_D:
                begin
                    state_d.rdata = mask_d & `CEM_WR_MASK_D;
                    state_d.rhit = 1'b1;
                end
                `CEM_OFS_MASK_F:
                begin
                    state_d.rdata = mask_f;
                    state_d.rhit = 1'b1;
                end
                default:
                begin
                    state_d.rdata = 8'h00;
                    state_d.rhit = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            state_q <= '0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign int_pulse_o = state_q.int_pulse;
    assign flag_set_c_o = state_q.flag_c;
    assign flag_set_d_o = state_q.flag_d;
    assign flag_set_f_o = state_q.flag_f;
    assign reg_rdata_o = state_q.rdata;
    assign reg_rvalid_o = state_q.rvalid;
    assign reg_hit_o = state_q.rhit;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    dl_done_a: assert property (ev_dataline_detect_done_i && !mask_c[6] |=> int_pulse_o)
        else $error("dataline detect done did not pulse interrupt");
    conv_done_a: assert property (ev_conv_done_i && conv_oneshot_i && !mask_c[5]
        |=> int_pulse_o)
        else $error("one-shot conversion done did not pulse interrupt");
    sys_min_a: assert property (ev_sys_min_reg_i && !mask_c[4] |=> int_pulse_o)
        else $error("min system regulation change did not pulse interrupt");
    timer_gate_a: assert property (|({ev_fast_charge_timer_i, ev_trickle_timer_i,
        ev_precharge_timer_i, ev_topoff_timer_i} & ~mask_c[3:0]) |=> int_pulse_o)
        else $error("charge timer expiry did not pulse interrupt");
    batt_low_a: assert property (ev_batt_low_reverse_i && !mask_d[4] |=> int_pulse_o)
        else $error("battery low reverse event did not pulse interrupt");
    therm_gate_a: assert property (|({ev_therm_cold_i, ev_therm_cool_i, ev_therm_warm_i,
        ev_therm_hot_i} & ~mask_d[3:0]) |=> int_pulse_o)
        else $error("thermistor crossing did not pulse interrupt");
    wdog_clear_a: assert property (wdog_expire_i |=> (mask_d == 8'h00) [*1])
        else $error("watchdog did not clear mask d");
    cur_reg_a: assert property (ev_batt_current_reg_i && !mask_f[7] |=> int_pulse_o)
        else $error("battery current regulation did not pulse interrupt");
    ovp_gate_a: assert property (|({ev_bus_overvolt_i, ev_batt_overvolt_i,
        ev_input2_overvolt_i, ev_input1_overvolt_i}
        & ~{mask_f[6], mask_f[5], mask_f[1], mask_f[0]}) |=> int_pulse_o)
        else $error("over-voltage entry did not pulse interrupt");
    ocp_gate_a: assert property (|({ev_input_overcurrent_i, ev_batt_overcurrent_i,
        ev_converter_overcurrent_i} & ~mask_f[4:2]) |=> int_pulse_o)
        else $error("over-current fault did not pulse interrupt");
    wdog_keep_a: assert property (wdog_expire_i && !reg_rst_i && !wr_c && !wr_f
        |=> mask_c == $past(mask_c) && mask_f == $past(mask_f))
        else $error("watchdog disturbed mask c or fault mask");
    reg_rst_a: assert property (reg_rst_i |=> mask_c == 8'h00 && mask_f == 8'h00)
        else $error("register reset did not clear masks");
    rsvd_zero_a: assert property (reg_rd_i && reg_addr_i == `CEM_OFS_MASK_D
        |=> reg_rvalid_o && reg_rdata_o[7:5] == 3'h0 && mask_c[7] == 1'b0)
        else $error("reserved mask bits not zero");
    suppress_a: assert property (int_pulse_o |-> $past(any_unmasked))
        else $error("interrupt pulse without an unmasked event");
    flag_kept_a: assert property (ev_therm_hot_i && mask_d[0] && !any_unmasked
        |=> flag_set_d_o[0] && !int_pulse_o)
        else $error("masked event lost its flag or still pulsed");

    masked_ev_c: cover property (ev_dataline_detect_done_i && mask_c[6] ##1 !int_pulse_o);
    wdog_clr_c: cover property (wr_d && reg_wdata_i[4] ##1 wdog_expire_i ##1 mask_d == 8'h00);
    fault_int_c: cover property (ev_bus_overvolt_i && !mask_f[6] ##1 int_pulse_o);
    read_c: cover property (reg_rd_i && reg_addr_i == `CEM_OFS_MASK_F ##1 reg_hit_o);

endmodule : cem_event_masks

// >>> src/cem_mask_reg.sv
`timescale 1ns/10ps
`include "cem_defs.svh"

module cem_mask_reg
    import cem_pkg::*;
#(
    parameter int REG_W = 8,
    parameter logic [7:0] WR_MASK = 8'hFF,
    parameter logic [7:0] RST_VAL = 8'h00
)
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic soft_clr_i,
    input wire logic wr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] value_o
);

    if (REG_W != `CEM_REG_W)
    begin : g_width_check
        $error("cem_mask_reg supports only 8-bit registers");
    end

    cem_mask_reg_s state_q;
    cem_mask_reg_s state_d;

    always_comb
    begin
        state_d = state_q;
        // A soft clear outranks a write landing in the same cycle
        if (soft_clr_i)
        begin
            state_d.val = RST_VAL & WR_MASK;
        end
        else if (wr_i)
        begin
            state_d.val = wdata_i & WR_MASK;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            state_q <= '{val: RST_VAL & WR_MASK};
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign value_o = state_q.val;

endmodule : cem_mask_reg

// >>> src/cem_pkg.sv
package cem_pkg;

    typedef logic [7:0] cem_byte_t;

    typedef struct packed {
        cem_byte_t val;
    } cem_mask_reg_s;

    typedef struct packed {
        logic int_pulse;
        cem_byte_t flag_c;
        cem_byte_t flag_d;
        cem_byte_t flag_f;
        cem_byte_t rdata;
        logic rvalid;
        logic rhit;
    } cem_state_s;

    // Events that reach the interrupt line: an event survives where its mask bit is 0
    function automatic cem_byte_t cem_unmasked(input cem_byte_t ev, input cem_byte_t mask);
        return ev & ~mask;
    endfunction : cem_unmasked

endpackage : cem_pkg

// >>> testbench/cem_host_model.sv
`timescale 1ns/10ps

module cem_host_model
(
    input wire logic clk_sys_i,
    input wire logic [7:0] rdata_i,
    input wire logic rvalid_i,
    input wire logic hit_i,
    output logic [7:0] addr_o,
    output logic wr_o,
    output logic rd_o,
    output logic [7:0] wdata_o
);
    initial
    begin
        addr_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = 8'h00;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys_i);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge clk_sys_i);
        wr_o = 1'b0;
        // Released lines show the inverse, so a stale value is never mistaken for data
        addr_o = ~a;
        wdata_o = ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [9:0] r);
        @(negedge clk_sys_i);
        addr_o = a;
        rd_o = 1'b1;
        @(negedge clk_sys_i);
        rd_o = 1'b0;
        addr_o = ~a;
        r = {rvalid_i, hit_i, rdata_i};
    endtask : rd
endmodule : cem_host_model

// >>> testbench/charger_event_interrupt_masks_test.sv
`timescale 1ns/10ps

module charger_event_interrupt_masks_test;
    typedef struct packed {
        logic [23:0] m;
        logic [23:0] e;
        logic o;
        logic p;
    } cem_tb_row_s;

    localparam logic [23:0] WRM = 24'h7F1FFF;
    localparam cem_tb_row_s ROWS [12] = '{
        '{24'h000000, 24'h400000, 1'b1, 1'b1}, '{24'h400000, 24'h400000, 1'b1, 1'b0},
        '{24'h000000, 24'h200000, 1'b0, 1'b0}, '{24'h200000, 24'h200000, 1'b1, 1'b0},
        '{24'h000000, 24'h100000, 1'b1, 1'b1}, '{24'h0F0000, 24'h0F0000, 1'b1, 1'b0},
        '{24'h001000, 24'h001000, 1'b1, 1'b0}, '{24'h000F00, 24'h000F00, 1'b1, 1'b0},
        '{24'h000080, 24'h000080, 1'b1, 1'b0}, '{24'h000063, 24'h000063, 1'b1, 1'b0},
        '{24'h00001C, 24'h00001C, 1'b1, 1'b0}, '{24'h00001C, 24'h00001D, 1'b1, 1'b1}};

    logic clk_sys_i = 1'b0;
    logic rst_i, reg_rst, wdog, os, pulse, rvalid, hit, wr, rd;
    logic [23:0] ev;
    logic [7:0] addr, wdata, rdata, fc, fd, ff;
    int fail_count = 0;
    int checks_done = 0;

    always #5 clk_sys_i = ~clk_sys_i;

    cem_host_model host_u (.clk_sys_i(clk_sys_i), .rdata_i(rdata), .rvalid_i(rvalid),
        .hit_i(hit), .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wdata));

    cem_event_masks dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_rst_i(reg_rst),
        .wdog_expire_i(wdog), .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .reg_hit_o(hit),
        .conv_oneshot_i(os), .ev_dataline_detect_done_i(ev[22]), .ev_conv_done_i(ev[21]),
        .ev_sys_min_reg_i(ev[20]), .ev_fast_charge_timer_i(ev[19]),
        .ev_trickle_timer_i(ev[18]), .ev_precharge_timer_i(ev[17]),
        .ev_topoff_timer_i(ev[16]), .ev_batt_low_reverse_i(ev[12]),
        .ev_therm_cold_i(ev[11]), .ev_therm_cool_i(ev[10]), .ev_therm_warm_i(ev[9]),
        .ev_therm_hot_i(ev[8]), .ev_batt_current_reg_i(ev[7]), .ev_bus_overvolt_i(ev[6]),
        .ev_batt_overvolt_i(ev[5]), .ev_input_overcurrent_i(ev[4]),
        .ev_batt_overcurrent_i(ev[3]), .ev_converter_overcurrent_i(ev[2]),
        .ev_input2_overvolt_i(ev[1]), .ev_input1_overvolt_i(ev[0]), .flag_set_c_o(fc),
        .flag_set_d_o(fd), .flag_set_f_o(ff), .int_pulse_o(pulse));

    task automatic tally_and_finish;
        $display("checks %0d failures %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
        begin
            $display("STATUS OK");
        end
        else
        begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    task automatic rdchk(input logic [7:0] a, input logic [9:0] exp);
        logic [9:0] r;
        host_u.rd(a, r);
        cmp({14'h0, r}, {14'h0, exp});
    endtask : rdchk

    task automatic wr3(input logic [23:0] m);
        host_u.wr(8'h2A, m[23:16]);
        host_u.wr(8'h2B, m[15:8]);
        host_u.wr(8'h2C, m[7:0]);
    endtask : wr3

    // Conversion-done flag only counts while the converter is in one-shot mode
    task automatic evchk(input logic [23:0] e, input logic o, input logic p);
        @(negedge clk_sys_i);
        ev = e;
        os = o;
        @(negedge clk_sys_i);
        ev = 24'h0;
        cmp({fc, fd, ff}, e & (o ? WRM : 24'h5F1FFF));
        cmp({23'h0, pulse}, {23'h0, p});
        // The pulse stands for one cycle only
        @(negedge clk_sys_i);
        cmp({23'h0, pulse}, 24'h0);
    endtask : evchk

    task automatic pulse_in(input logic w);
        @(negedge clk_sys_i);
        if (w) wdog = 1'b1;
        else reg_rst = 1'b1;
        @(negedge clk_sys_i);
        wdog = 1'b0;
        reg_rst = 1'b0;
    endtask : pulse_in

    initial
    begin
        rst_i = 1'b1;
        reg_rst = 1'b0;
        wdog = 1'b0;
        os = 1'b1;
        ev = 24'h0;
        repeat (20) @(negedge clk_sys_i);
        rst_i = 1'b0;
        rdchk(8'h2A, 10'h300);
        rdchk(8'h2B, 10'h300);
        rdchk(8'h2C, 10'h300);
        rdchk(8'h2D, 10'h200);
        foreach (ROWS[i])
        begin
            wr3(ROWS[i].m);
            evchk(ROWS[i].e, ROWS[i].o, ROWS[i].p);
        end
        wr3(24'h0);
        for (int i = 0; i < 24; i++)
        begin
            if (WRM[i]) evchk(24'h1 << i, 1'b1, 1'b1);
        end
        wr3(24'hFFFFFF);
        rdchk(8'h2A, 10'h37F);
        rdchk(8'h2B, 10'h31F);
        pulse_in(1'b1);
        rdchk(8'h2A, 10'h37F);
        rdchk(8'h2B, 10'h300);
        rdchk(8'h2C, 10'h3FF);
        wr3(24'hFFFFFF);
        evchk(WRM, 1'b1, 1'b0);
        pulse_in(1'b0);
        rdchk(8'h2A, 10'h300);
        rdchk(8'h2B, 10'h300);
        rdchk(8'h2C, 10'h300);
        // Clears beat a write landing in the same cycle
        fork
            host_u.wr(8'h2B, 8'h1F);
            pulse_in(1'b1);
        join
        rdchk(8'h2B, 10'h300);
        fork
            host_u.wr(8'h2A, 8'h7F);
            pulse_in(1'b0);
        join
        rdchk(8'h2A, 10'h300);
        // Power-on reset in mid-run, with events held high while it stands
        wr3(24'hFFFFFF);
        @(negedge clk_sys_i);
        rst_i = 1'b1;
        ev = WRM;
        repeat (2) @(negedge clk_sys_i);
        cmp({fc, fd, ff}, 24'h0);
        cmp({23'h0, pulse}, 24'h0);
        ev = 24'h0;
        rst_i = 1'b0;
        rdchk(8'h2A, 10'h300);
        rdchk(8'h2B, 10'h300);
        rdchk(8'h2C, 10'h300);
        tally_and_finish();
    end

    // Whole run takes well under 2000 cycles
    initial
    begin
        #100000;
        fail_count++;
        $display("FAIL %0t run did not finish in time", $time);
        tally_and_finish();
    end
endmodule : charger_event_interrupt_masks_test
